// [rtl/port_bank_pkg.sv]
// shared constants and carrier types for the peripheral port bank
package port_bank_pkg;
  // register index width on the pointer bus
  localparam int IDX_W = 4;
  // pointer indices, second table (index 0 is table select)
  localparam logic [3:0] IDX_TABLE_SELECT = 4'h0;
  localparam logic [3:0] IDX_PROG_ONE = 4'h1;
  localparam logic [3:0] IDX_PROG_TWO = 4'h2;
  localparam logic [3:0] IDX_FIX_C = 4'h3;
  localparam logic [3:0] IDX_FIX_D = 4'h4;
  localparam logic [3:0] IDX_FIX_E = 4'h5;
  localparam logic [3:0] IDX_FIX_F = 4'h6;
  localparam logic [3:0] IDX_FIX_G = 4'h7;
  localparam logic [3:0] IDX_FIX_H = 4'h8;
  localparam logic [3:0] IDX_ANALOG = 4'h9;
  localparam logic [3:0] IDX_CONVERTER = 4'hA;
  localparam logic [3:0] IDX_INTERRUPT = 4'hB;
  localparam logic [3:0] IDX_SERIAL = 4'hC;
  localparam logic [3:0] IDX_DIRECTION = 4'hD;
  // table select values
  localparam logic TABLE_FIRST = 1'b0;
  localparam logic TABLE_SECOND = 1'b1;
  // field positions
  localparam int DIR_PROG_ONE_BIT = 0;
  localparam int DIR_PROG_TWO_BIT = 1;
  localparam int EDGE_FLAG_BIT = 2;
  localparam int EDGE_LINE_BIT = 1;
  // reset values
  localparam logic [3:0] RST_DATA = 4'h0;
  localparam logic [1:0] RST_DIRECTION = 2'h0;
  localparam logic RST_TABLE = 1'b0;
  // port widths
  localparam int W_PROG = 4;
  localparam int W_C = 2;
  localparam int W_D = 4;
  localparam int W_E = 4;
  localparam int W_F = 3;
  localparam int W_G = 2;
  localparam int W_H = 2;
  localparam int W_ANALOG = 4;
  localparam int W_CONV = 2;
  localparam int W_INTR = 2;
  localparam int W_SERIAL = 2;

  // register access request from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] idx;
    logic [3:0] wdata;
  } reg_req_t;
endpackage

// [rtl/peripheral_io_port_bank.sv]
// parallel port bank behind the core's indexed peripheral registers
// pointer index 0: table select, answers in both tables
// indices 1 to D: port registers, second table only
// first-table registers belong to another block
// reads registered: rdata_o holds until the next read
// pin drives follow their registers one clock later
// open-drain enable high on lines the bank pulls low
// programmable port pulls its zero bits while set as output
// build-time port directions are masks, 1 = output
// seventh port line 1 feeds a sticky edge flag in bit 2
`timescale 1ns/1ps
module peripheral_io_port_bank #(
  // build-time direction masks of the fixed ports
  parameter logic [1:0] C_OUT_MASK = 2'b11, // 1 = output bit
  parameter logic [3:0] D_OUT_MASK = 4'hF,
  parameter logic [3:0] E_OUT_MASK = 4'hF,
  parameter logic [2:0] F_OUT_MASK = 3'h7,
  parameter logic [1:0] G_OUT_MASK = 2'h3,
  parameter logic [1:0] H_OUT_MASK = 2'h0,
  // serial line 1 direction and edge polarity, build time
  parameter logic SERIAL_LINE1_OUT = 1'b0, // serial line 1 direction
  parameter logic EDGE_RISING = 1'b1 // edge detector polarity
) (
  // clock, reset and register access
  input wire logic clock_i, // core clock
  input wire logic arst_n_i, // async reset, low
  input wire port_bank_pkg::reg_req_t req_i, // core register access
  output logic [3:0] rdata_o, // read data, one cycle after rd
  output logic table_sel_o, // selected table
  // programmable open-drain ports
  input wire logic [3:0] prog_one_i, // port one pin levels
  output logic [3:0] prog_one_o, // port one drive value (low pulls)
  output logic [3:0] prog_one_oe_o, // port one open-drain enable
  input wire logic [3:0] prog_two_i, // port two pin levels
  output logic [3:0] prog_two_o, // port two drive value
  output logic [3:0] prog_two_oe_o, // port two open-drain enable
  // build-time direction ports
  input wire logic [1:0] fix_c_i, // third port pins
  output logic [1:0] fix_c_o, // third port drive
  input wire logic [3:0] fix_d_i, // fourth port pins
  output logic [3:0] fix_d_o, // fourth port drive
  input wire logic [3:0] fix_e_i, // fifth port pins
  output logic [3:0] fix_e_o, // fifth port drive
  input wire logic [2:0] fix_f_i, // sixth port pins
  output logic [2:0] fix_f_o, // sixth port drive
  input wire logic [1:0] fix_g_i, // second-table port g pins
  output logic [1:0] fix_g_o, // port g drive
  input wire logic [1:0] seventh_port_i, // seventh port pins
  output logic [1:0] seventh_port_o, // seventh port drive
  // input-only shared ports
  input wire logic [3:0] analog_input_i, // shared analog pins
  input wire logic [1:0] converter_pins_i, // reference, clock pin
  input wire logic [1:0] interrupt_pins_i, // interrupt, counter pin
  // serial shared port
  input wire logic serial_in_out_pin_i, // serial line 1 level
  output logic serial_out_pin_o, // serial line 0 drive
  output logic serial_in_out_pin_o // serial line 1 drive
);
  // decoded strobes
  // second table open: port registers visible
  wire logic sel_second = table_sel_o == port_bank_pkg::TABLE_SECOND;
  // any write from the core
  wire logic wr_any = req_i.wr;
  // table select writable from either table
  wire logic wr_table = wr_any &&
    req_i.idx == port_bank_pkg::IDX_TABLE_SELECT;
  // port writes need the second table
  wire logic wr_two = wr_any && sel_second;
  // one write strobe per writable register index; the input-only indices 9 to B have none
  wire logic wr_one_s = wr_two && req_i.idx == port_bank_pkg::IDX_PROG_ONE;
  wire logic wr_two_s = wr_two && req_i.idx == port_bank_pkg::IDX_PROG_TWO;
  wire logic wr_c = wr_two && req_i.idx == port_bank_pkg::IDX_FIX_C;
  wire logic wr_d = wr_two && req_i.idx == port_bank_pkg::IDX_FIX_D;
  wire logic wr_e = wr_two && req_i.idx == port_bank_pkg::IDX_FIX_E;
  wire logic wr_f = wr_two && req_i.idx == port_bank_pkg::IDX_FIX_F;
  wire logic wr_g = wr_two && req_i.idx == port_bank_pkg::IDX_FIX_G;
  wire logic wr_h = wr_two && req_i.idx == port_bank_pkg::IDX_FIX_H;
  wire logic wr_ser = wr_two && req_i.idx == port_bank_pkg::IDX_SERIAL;
  wire logic wr_dir = wr_two && req_i.idx == port_bank_pkg::IDX_DIRECTION;

  // stored registers
  // programmable port output data
  logic [3:0] one_reg; // port one data
  logic [3:0] two_reg; // port two data
  // build-time port latches at their port widths
  logic [1:0] c_reg;
  logic [3:0] d_reg;
  logic [3:0] e_reg;
  logic [2:0] f_reg;
  logic [1:0] g_reg;
  logic [1:0] h_reg; // seventh port latch
  logic [1:0] ser_reg; // serial port latch
  // direction control, one bit per programmable port
  logic [1:0] dir_reg; // direction bits
  // edge detector state
  logic edge_flag_reg; // sticky edge bit
  logic edge_prev_reg; // previous seventh line 1 level
  logic edge_arm_reg; // high from the first clock after reset

  // direction controls
  // a port drives only while its bit is set
  wire logic one_out = dir_reg[port_bank_pkg::DIR_PROG_ONE_BIT];
  wire logic two_out = dir_reg[port_bank_pkg::DIR_PROG_TWO_BIT];

  // edge detect on seventh port line 1 when input
  // pin level under watch
  wire logic line1 = seventh_port_i[port_bank_pkg::EDGE_LINE_BIT];
  // detector works only where the line is built as an input
  wire logic line1_in = !H_OUT_MASK[port_bank_pkg::EDGE_LINE_BIT];
  // no edge taken on the first clock after reset: a pin idling
  // at the active level would otherwise raise a false flag
  wire logic edge_seen = edge_arm_reg && line1_in && (EDGE_RISING ?
    (line1 && !edge_prev_reg) : (!line1 && edge_prev_reg));

  // live-read data: inputs from pins; outputs from register on programmable ports, zero elsewhere
  // programmable ports: stored data while output, pins while input
  wire logic [3:0] rd_one = one_out ? one_reg : prog_one_i;
  wire logic [3:0] rd_two = two_out ? two_reg : prog_two_i;
  // build-time ports: output bits read zero, inputs read pins
  wire logic [3:0] rd_c = {2'h0, fix_c_i & ~C_OUT_MASK};
  wire logic [3:0] rd_d = fix_d_i & ~D_OUT_MASK;
  wire logic [3:0] rd_e = fix_e_i & ~E_OUT_MASK;
  // narrow ports padded with zeros above
  wire logic [3:0] rd_f = {1'b0, fix_f_i & ~F_OUT_MASK};
  wire logic [3:0] rd_g = {2'h0, fix_g_i & ~G_OUT_MASK};
  // seventh port: sticky flag above the two pins
  wire logic [3:0] rd_h = {1'b0, edge_flag_reg,
    seventh_port_i & ~H_OUT_MASK};
  // serial port: line 0 always output, line 1 as built
  wire logic [1:0] ser_in_mask = {~SERIAL_LINE1_OUT, 1'b0};
  wire logic [3:0] rd_ser = {2'h0, {serial_in_out_pin_i, 1'b0}
    & ser_in_mask};

  // read mux by pointer and table
  // decoded every cycle; rdata_o samples it on a read
  logic [3:0] rd_mux;
  always_comb begin
    rd_mux = 4'h0; // unmapped reads zero
    if (req_i.idx == port_bank_pkg::IDX_TABLE_SELECT) begin
      // table select answers in both tables
      rd_mux = {3'h0, table_sel_o};
    end else if (sel_second) begin
      // port registers answer only in the second table
      case (req_i.idx)
        port_bank_pkg::IDX_PROG_ONE: rd_mux = rd_one;
        port_bank_pkg::IDX_PROG_TWO: rd_mux = rd_two;
        port_bank_pkg::IDX_FIX_C: rd_mux = rd_c;
        port_bank_pkg::IDX_FIX_D: rd_mux = rd_d;
        port_bank_pkg::IDX_FIX_E: rd_mux = rd_e;
        port_bank_pkg::IDX_FIX_F: rd_mux = rd_f;
        port_bank_pkg::IDX_FIX_G: rd_mux = rd_g;
        port_bank_pkg::IDX_FIX_H: rd_mux = rd_h;
        // input-only shared ports read the live pins
        port_bank_pkg::IDX_ANALOG: rd_mux = analog_input_i;
        port_bank_pkg::IDX_CONVERTER:
          rd_mux = {2'h0, converter_pins_i};
        port_bank_pkg::IDX_INTERRUPT:
          rd_mux = {2'h0, interrupt_pins_i};
        port_bank_pkg::IDX_SERIAL: rd_mux = rd_ser;
        // direction control, upper bits zero
        port_bank_pkg::IDX_DIRECTION: rd_mux = {2'h0, dir_reg};
        // indices E and F are unused
        default: rd_mux = 4'h0;
      endcase
    end
  end

  // table select and direction control
  // plain write-and-hold registers
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      table_sel_o <= port_bank_pkg::RST_TABLE;
      dir_reg <= port_bank_pkg::RST_DIRECTION;
    end else begin
      // table select taken in either table
      if (wr_table) table_sel_o <= req_i.wdata[0];
      // only two direction bits exist; the rest are dropped
      if (wr_dir) dir_reg <= req_i.wdata[1:0];
    end
  end

  // programmable port data, written in any direction
  // the stored value reaches the pins once a port is an output
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      one_reg <= port_bank_pkg::RST_DATA;
      two_reg <= port_bank_pkg::RST_DATA;
    end else begin
      if (wr_one_s) one_reg <= req_i.wdata;
      if (wr_two_s) two_reg <= req_i.wdata;
    end
  end

  // fixed port data latches, only output bits kept; the serial latch keeps both bits
  // input bits are masked so they can never drive
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      c_reg <= 2'h0;
      d_reg <= port_bank_pkg::RST_DATA;
      e_reg <= port_bank_pkg::RST_DATA;
      f_reg <= 3'h0;
      g_reg <= 2'h0;
      h_reg <= 2'h0;
      ser_reg <= 2'h0;
    end else begin
      if (wr_c) c_reg <= req_i.wdata[1:0] & C_OUT_MASK;
      if (wr_d) d_reg <= req_i.wdata & D_OUT_MASK;
      if (wr_e) e_reg <= req_i.wdata & E_OUT_MASK;
      if (wr_f) f_reg <= req_i.wdata[2:0] & F_OUT_MASK;
      if (wr_g) g_reg <= req_i.wdata[1:0] & G_OUT_MASK;
      if (wr_h) h_reg <= req_i.wdata[1:0] & H_OUT_MASK;
      if (wr_ser) ser_reg <= req_i.wdata[1:0];
    end
  end

  // sticky edge flag: set wins over the clearing write
  // a write to the seventh port register is the only clear
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      edge_flag_reg <= 1'b0; // flag clear
      edge_prev_reg <= 1'b0; // history not yet valid
      edge_arm_reg <= 1'b0; // detector held off
    end else begin
      edge_arm_reg <= 1'b1; // history valid from here on
      edge_prev_reg <= line1;
      if (edge_seen) edge_flag_reg <= 1'b1;
      else if (wr_h) edge_flag_reg <= 1'b0;
    end
  end

  // registered read data, held between reads
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 4'h0; // nothing read yet
    end else begin
      rdata_o <= req_i.rd ? rd_mux : rdata_o;
    end
  end

  // programmable port drives; a line is pulled only for a zero
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prog_one_o <= 4'h0;
      prog_one_oe_o <= 4'h0; // released while inputs
      prog_two_o <= 4'h0;
      prog_two_oe_o <= 4'h0; // released while inputs
    end else begin
      prog_one_o <= one_reg;
      // enables: pull the zero bits of an output port
      prog_one_oe_o <= {4{one_out}} & ~one_reg;
      prog_two_o <= two_reg;
      prog_two_oe_o <= {4{two_out}} & ~two_reg;
    end
  end

  // build-time port and serial port drives
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fix_c_o <= 2'h0;
      fix_d_o <= 4'h0;
      fix_e_o <= 4'h0;
      fix_f_o <= 3'h0;
      fix_g_o <= 2'h0;
      seventh_port_o <= 2'h0;
      serial_out_pin_o <= 1'b0;
      serial_in_out_pin_o <= 1'b0;
    end else begin
      // build-time ports drive their masked latches
      fix_c_o <= c_reg;
      fix_d_o <= d_reg;
      fix_e_o <= e_reg;
      fix_f_o <= f_reg;
      fix_g_o <= g_reg;
      seventh_port_o <= h_reg;
      // serial line 1 drives only when built as output
      serial_out_pin_o <= ser_reg[0];
      serial_in_out_pin_o <= ser_reg[1] & SERIAL_LINE1_OUT;
    end
  end

  // line budget of the bank, all on the ports above
  //   general lines 4 + 4 + 2 + 4 + 4 + 3 + 2 + 2 = 25
  //   dual-function lines 4 analog, 2 converter, 2 interrupt,
  //   2 serial = 10
endmodule

// [sim/port_bank_chk.sv]
// concurrent checks on the port bank register and pin behaviour
`timescale 1ns/1ps
module port_bank_chk (
  input wire logic clock_i, // core clock
  input wire logic arst_n_i, // async reset, low
  input wire port_bank_pkg::reg_req_t req_i, // core register access
  input wire logic [3:0] rdata_o, // read data
  input wire logic table_sel_o, // selected table
  input wire logic [3:0] prog_one_o, // port one drive value
  input wire logic [3:0] prog_one_oe_o, // port one pull enable
  input wire logic [3:0] prog_two_o, // port two drive value
  input wire logic [3:0] prog_two_oe_o, // port two pull enable
  input wire logic [3:0] analog_input_i // shared analog pins
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // port one data write while the second table is open
  sequence one_wr_s;
    req_i.wr && table_sel_o && req_i.idx == port_bank_pkg::IDX_PROG_ONE;
  endsequence
  // read of an index that the first table hides
  sequence hidden_rd_s;
    req_i.rd && !table_sel_o && req_i.idx != 4'h0;
  endsequence
  table_write_a: assert property (
    req_i.wr && req_i.idx == 4'h0 |=> table_sel_o == $past(req_i.wdata[0]))
    else $error("table select did not take written bit");
  table_hold_a: assert property (
    !(req_i.wr && req_i.idx == 4'h0) |=> $stable(table_sel_o))
    else $error("table select moved without a write");
  one_pins_a: assert property (
    one_wr_s |=> ##1 prog_one_o == $past(req_i.wdata, 2))
    else $error("port one pins differ from written data");
  one_group_a: assert property (
    prog_one_oe_o != 4'h0 |-> prog_one_oe_o == ~prog_one_o)
    else $error("port one lines not driven as one group");
  two_group_a: assert property (
    prog_two_oe_o != 4'h0 |-> prog_two_oe_o == ~prog_two_o)
    else $error("port two lines not driven as one group");
  read_hold_a: assert property (!req_i.rd |=> $stable(rdata_o))
    else $error("read data changed without a read");
  hidden_read_a: assert property (hidden_rd_s |=> rdata_o == 4'h0)
    else $error("first table read returned port data");
  unused_read_a: assert property (
    req_i.rd && req_i.idx >= 4'hE |=> rdata_o == 4'h0)
    else $error("unused index read not zero");
  analog_read_a: assert property (
    req_i.rd && table_sel_o && req_i.idx == port_bank_pkg::IDX_ANALOG
    |=> rdata_o == $past(analog_input_i))
    else $error("analog port read not live pins");
endmodule

// [sim/pin_load_model.sv]
// open-drain line with pull-up and an outside driver behind it
`timescale 1ns/1ps
module pin_load_model (
  input wire logic [3:0] ext_i, // level the outside circuit offers
  input wire logic [3:0] oe_i, // bank pulls the line low where high
  output logic [3:0] pin_o // resolved line level
);
  // wired-and: a pulling bank always wins over the pull-up
  assign pin_o = ext_i & ~oe_i;
endmodule

// [sim/peripheral_io_port_bank_bench.sv]
// self-checking bench for the peripheral port bank
`timescale 1ns/1ps
module peripheral_io_port_bank_bench;
  typedef struct packed {
    logic [3:0] idx; logic [3:0] wd; logic [3:0] rd; logic [3:0] mk;
  } row_t;
  logic clock_i = 1'b0; // core clock
  logic arst_n_i = 1'b0; // reset, low
  port_bank_pkg::reg_req_t req_i = '0; // core request
  logic [3:0] rdata_o, prog_one_o, prog_one_oe_o, prog_two_o, prog_two_oe_o;
  logic [3:0] prog_one_i, prog_two_i, fix_d_o, fix_e_o;
  logic [3:0] analog_input_i = 4'h9; // shared analog pins
  logic [1:0] fix_c_o, fix_g_o, seventh_port_o, seventh_port_i = 2'h1;
  logic [1:0] converter_pins_i = 2'h2, interrupt_pins_i = 2'h1;
  logic [2:0] fix_f_o;
  logic table_sel_o, serial_out_pin_o, serial_in_out_pin_o;
  logic serial_in_out_pin_i = 1'b1; // serial line 1 level
  logic [3:0] one_ext = 4'hA; // outside level on port one
  logic [3:0] two_ext = 4'h5; // outside level on port two
  int miscompares = 0;
  int num_checks = 0;
  // write, then read back under mask
  row_t rows [13] = '{'{4'h1,4'h3,4'hA,4'hF}, '{4'h2,4'h6,4'h5,4'hF},
    '{4'h3,4'h3,4'h0,4'hF}, '{4'h4,4'hF,4'h0,4'hF}, '{4'h5,4'h5,4'h0,4'hF},
    '{4'h6,4'h7,4'h0,4'hF}, '{4'h7,4'h2,4'h0,4'hF}, '{4'h8,4'h3,4'h1,4'hF},
    '{4'h9,4'hF,4'h9,4'hF}, '{4'hA,4'h0,4'h2,4'hF}, '{4'hB,4'h0,4'h1,4'hF},
    '{4'hC,4'h3,4'h2,4'h2}, '{4'hE,4'hF,4'h0,4'hF}};
  peripheral_io_port_bank peripheral_io_port_bank_inst (.clock_i, .arst_n_i,
    .req_i, .rdata_o, .table_sel_o, .prog_one_i, .prog_one_o, .prog_one_oe_o,
    .prog_two_i, .prog_two_o, .prog_two_oe_o, .fix_c_i(2'h3), .fix_c_o,
    .fix_d_i(4'hF), .fix_d_o, .fix_e_i(4'hF), .fix_e_o, .fix_f_i(3'h7),
    .fix_f_o, .fix_g_i(2'h3), .fix_g_o, .seventh_port_i, .seventh_port_o,
    .analog_input_i, .converter_pins_i, .interrupt_pins_i,
    .serial_in_out_pin_i, .serial_out_pin_o, .serial_in_out_pin_o);
  // outside circuits on the two open-drain ports
  pin_load_model one_load_inst (.ext_i(one_ext), .oe_i(prog_one_oe_o),
    .pin_o(prog_one_i));
  pin_load_model two_load_inst (.ext_i(two_ext), .oe_i(prog_two_oe_o),
    .pin_o(prog_two_i));
  // free-running core clock
  always #12.5 clock_i = ~clock_i;
  task automatic chk(input string nm, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one-cycle request; read data is settled on return
  task automatic acc(input logic w, input logic [3:0] i, d);
    @(posedge clock_i);
    req_i <= '{wr: w, rd: !w, idx: i, wdata: d};
    @(posedge clock_i);
    req_i <= '0;
    #1;
  endtask
  // let registered pin outputs follow
  task automatic settle;
    @(posedge clock_i);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clock_i);
    arst_n_i <= 1'b1;
    #1;
    chk("reset", {table_sel_o, prog_one_oe_o, prog_two_oe_o}, 0);
    chk("reset data", {fix_c_o, fix_d_o, fix_e_o, prog_one_o}, 0);
    acc(1'b1, 4'h1, 4'hF);
    acc(1'b0, 4'h1, 4'h0);
    chk("first table read", rdata_o, 0);
    acc(1'b1, 4'h0, 4'h1);
    chk("table", table_sel_o, 1);
    foreach (rows[n]) begin
      acc(1'b1, rows[n].idx, rows[n].wd);
      acc(1'b0, rows[n].idx, 4'h0);
      chk("row read", rdata_o & rows[n].mk, rows[n].rd);
    end
    settle();
    chk("fixed outs", {fix_c_o, fix_d_o, fix_e_o, fix_f_o, fix_g_o,
      serial_out_pin_o}, {2'h3, 4'hF, 4'h5, 3'h7, 2'h2, 1'b1});
    chk("idle drives", {seventh_port_o, serial_in_out_pin_o}, 0);
    chk("early enables", {prog_one_oe_o, prog_two_oe_o}, 0);
    acc(1'b1, 4'hD, 4'h3);
    settle();
    chk("enables", {prog_one_oe_o, prog_two_oe_o}, {~4'h3, ~4'h6});
    chk("drive", {prog_one_o, prog_two_o}, {4'h3, 4'h6});
    acc(1'b1, 4'hD, 4'hE);
    acc(1'b0, 4'hD, 4'h0);
    chk("direction", rdata_o, 4'h2);
    acc(1'b0, 4'h1, 4'h0);
    chk("port one input", rdata_o, 4'hA);
    @(posedge clock_i);
    one_ext <= 4'h3;
    two_ext <= 4'h0;
    acc(1'b0, 4'h1, 4'h0);
    chk("port one live", rdata_o, 4'h3);
    acc(1'b0, 4'h2, 4'h0);
    chk("port two stored", rdata_o, 4'h6);
    @(posedge clock_i);
    seventh_port_i <= 2'h3;
    acc(1'b0, 4'h8, 4'h0);
    chk("edge flag", rdata_o, 4'h7);
    acc(1'b1, 4'h8, 4'h0);
    acc(1'b0, 4'h8, 4'h0);
    chk("edge cleared", rdata_o, 4'h3);
    @(posedge clock_i);
    arst_n_i <= 1'b0;
    settle();
    chk("mid reset", {table_sel_o, prog_two_oe_o}, 0);
    @(posedge clock_i);
    arst_n_i <= 1'b1;
    acc(1'b1, 4'h0, 4'h1);
    chk("table after reset", table_sel_o, 1);
    acc(1'b0, 4'h8, 4'h0);
    chk("no edge after reset", rdata_o, 4'h3);
    tally_and_finish();
  end
  // the run needs under 150 cycles; cut a hang well past that
  initial begin
    #20000;
    miscompares++;
    tally_and_finish();
  end
endmodule
bind peripheral_io_port_bank port_bank_chk port_bank_chk_inst (.clock_i,
  .arst_n_i, .req_i, .rdata_o, .table_sel_o, .prog_one_o, .prog_one_oe_o,
  .prog_two_o, .prog_two_oe_o, .analog_input_i);
